/* rtl/ocp_pkg.sv */
// constants, encodings and register map for the output channel power control block
package ocp_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFS_CHANNEL_POWER_DOWN  = 8'h1e;
  localparam logic [7:0] OFS_OUTPUT_ZERO_CONTROL = 8'h1f;
  localparam logic [7:0] OFS_OUTPUT_ONE_CONTROL  = 8'h20;

  // power-down register fields
  localparam int unsigned POS_PAIR_ZERO_ONE_OFF      = 0;
  localparam int unsigned POS_PAIR_TWO_THREE_OFF     = 1;
  localparam int unsigned POS_CHAN_FOUR_OFF          = 2;
  localparam int unsigned POS_CHAN_SEVEN_OFF         = 5;
  localparam int unsigned POS_SINGLE_ENDED_CHAN_OFF  = 6;
  localparam logic [7:0]  MASK_CHANNEL_POWER_DOWN    = 8'h7f;
  localparam logic [7:0]  RST_CHANNEL_POWER_DOWN     = 8'h00;

  // output control register fields
  localparam int unsigned POS_SOURCE   = 7;
  localparam int unsigned POS_FMT_HI   = 6;
  localparam int unsigned POS_FMT_LO   = 5;
  localparam int unsigned POS_DRA_HI   = 4;
  localparam int unsigned POS_DRA_LO   = 3;
  localparam int unsigned POS_DRB_HI   = 2;
  localparam int unsigned POS_DRB_LO   = 1;
  localparam logic [7:0]  MASK_OUTPUT_ZERO_CONTROL = 8'hfe;
  localparam logic [7:0]  MASK_OUTPUT_ONE_CONTROL  = 8'h7e;
  localparam logic [0:0]  RST_SOURCE   = 1'h1;
  localparam logic [1:0]  RST_FMT      = 2'h1;
  localparam logic [1:0]  RST_DRA      = 2'h2;
  localparam logic [1:0]  RST_DRB      = 2'h0;
  localparam logic [7:0]  RST_OUTPUT_ZERO_CONTROL = {RST_SOURCE, RST_FMT, RST_DRA, RST_DRB, 1'b0};
  localparam logic [7:0]  RST_OUTPUT_ONE_CONTROL  = {1'b0, RST_FMT, RST_DRA, RST_DRB, 1'b0};

  // source select
  localparam logic SRC_FIRST_SYNTH  = 1'b0;
  localparam logic SRC_SECOND_SYNTH = 1'b1;

  // driver format
  typedef enum logic [1:0] {
    OCP_FMT_OFF    = 2'h0,
    OCP_FMT_ACDIFF = 2'h1,
    OCP_FMT_HCSL   = 2'h2,
    OCP_FMT_CMOS   = 2'h3
  } ocp_fmt_e;

  // tail current selects, one-hot
  localparam logic [3:0] TAIL_4MA  = 4'h1;
  localparam logic [3:0] TAIL_6MA  = 4'h2;
  localparam logic [3:0] TAIL_8MA  = 4'h4;
  localparam logic [3:0] TAIL_16MA = 4'h8;

  // hcsl load selects, one-hot (zero = tristate)
  localparam logic [2:0] LOAD_50   = 3'h1;
  localparam logic [2:0] LOAD_100  = 3'h2;
  localparam logic [2:0] LOAD_200  = 3'h4;
endpackage

/* rtl/ocp_pin_decode.sv */
// single-ended pin mode decode shared by both pins of a channel
`timescale 1ns/1ps
module ocp_pin_decode (
  // mode field and enable
  input  wire logic [1:0] mode,
  input  wire logic       cmos_sel,
  // pin controls
  output logic            pin_en,
  output logic            pin_low,
  output logic            pin_invert
);
  // 0 tristate, 1 driven low, 2 up inverted, 3 up true
  always_comb begin
    pin_en     = cmos_sel && (mode != 2'h0);
    pin_low    = cmos_sel && (mode == 2'h1);
    pin_invert = cmos_sel && (mode == 2'h2);
  end
endmodule

/* rtl/ocp_driver_decode.sv */
// decode of one output driver control: format, tail current, load, cmos pins
`timescale 1ns/1ps
module ocp_driver_decode (
  // fields
  input  wire logic [1:0] fmt,
  input  wire logic [1:0] drive_a,
  input  wire logic [1:0] drive_b,
  // decoded controls
  output logic            drv_on,
  output logic            diff_on,
  output logic            hcsl_on,
  output logic [3:0]      tail_sel,
  output logic [2:0]      load_sel,
  output logic            p_en,
  output logic            p_low,
  output logic            p_inv,
  output logic            n_en,
  output logic            n_low,
  output logic            n_inv
);
  logic cmos_sel;

  always_comb begin
    drv_on   = (fmt != ocp_pkg::OCP_FMT_OFF);
    diff_on  = (fmt == ocp_pkg::OCP_FMT_ACDIFF) || (fmt == ocp_pkg::OCP_FMT_HCSL);
    hcsl_on  = (fmt == ocp_pkg::OCP_FMT_HCSL);
    cmos_sel = (fmt == ocp_pkg::OCP_FMT_CMOS);
    tail_sel = 4'h0;
    if (diff_on) begin
      unique case (drive_a)
        2'h0: tail_sel = ocp_pkg::TAIL_4MA;
        2'h1: tail_sel = ocp_pkg::TAIL_6MA;
        2'h2: tail_sel = ocp_pkg::TAIL_8MA;
        2'h3: tail_sel = hcsl_on ? ocp_pkg::TAIL_16MA : ocp_pkg::TAIL_8MA;
      endcase
    end
    load_sel = 3'h0;
    if (hcsl_on) begin
      unique case (drive_b)
        2'h0: load_sel = 3'h0;
        2'h1: load_sel = ocp_pkg::LOAD_50;
        2'h2: load_sel = ocp_pkg::LOAD_100;
        2'h3: load_sel = ocp_pkg::LOAD_200;
      endcase
    end
  end

  ocp_pin_decode u_pos (
    .mode       (drive_a),
    .cmos_sel   (cmos_sel),
    .pin_en     (p_en),
    .pin_low    (p_low),
    .pin_invert (p_inv)
  );

  ocp_pin_decode u_neg (
    .mode       (drive_b),
    .cmos_sel   (cmos_sel),
    .pin_en     (n_en),
    .pin_low    (n_low),
    .pin_invert (n_inv)
  );
endmodule

/* rtl/ocp_top.sv */
// register bank for channel power-down and output 0/1 driver control
// Overview of operation
// - channel 4-7 off bits disable mux and divider
// - bit 1 disables channel 2/3 mux, divider
// - bit 0 disables channel 0/1 mux, divider
// - bit 6 single-ended channel off; resets zero
// - bit 7 picks second synth; resets one
// - output 0 format decode, resets to 1
// - output 1 own format field; bit 7 reserved
// - drive field a: tail current or positive pin
// - drive field b: load or negative pin
`timescale 1ns/1ps
module ocp_top (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // channel power-down controls
  output logic            pair_zero_one_off,
  output logic            pair_two_three_off,
  output logic      [3:0] chan_four_to_seven_off,
  output logic            single_ended_channel_off,
  // pair zero/one source
  output logic            pair_zero_one_source,
  output logic            pair_zero_one_run,
  // output zero driver
  output logic            out_zero_drv_on,
  output logic            out_zero_diff_on,
  output logic            out_zero_hcsl_on,
  output logic      [3:0] out_zero_tail_sel,
  output logic      [2:0] out_zero_load_sel,
  output logic      [5:0] out_zero_pins,
  // output one driver
  output logic            out_one_drv_on,
  output logic            out_one_diff_on,
  output logic            out_one_hcsl_on,
  output logic      [3:0] out_one_tail_sel,
  output logic      [2:0] out_one_load_sel,
  output logic      [5:0] out_one_pins
);
  // register state
  logic [7:0] channel_power_down;
  logic [7:0] output_zero_control;
  logic [7:0] output_one_control;
  logic [7:0] next_channel_power_down;
  logic [7:0] next_output_zero_control;
  logic [7:0] next_output_one_control;
  logic [7:0] next_reg_rdata;

  // registered decoded controls
  logic       next_pair_zero_one_off;
  logic       next_pair_two_three_off;
  logic [3:0] next_chan_four_to_seven_off;
  logic       next_single_ended_channel_off;
  logic       next_pair_zero_one_source;
  logic       next_pair_zero_one_run;

  // decoder outputs, one set per driver
  logic       z_on;
  logic       z_diff;
  logic       z_hcsl;
  logic [3:0] z_tail;
  logic [2:0] z_load;
  logic [5:0] z_pins;
  logic       o_on;
  logic       o_diff;
  logic       o_hcsl;
  logic [3:0] o_tail;
  logic [2:0] o_load;
  logic [5:0] o_pins;

  // register writes and read mux
  always_comb begin
    next_channel_power_down  = channel_power_down;
    next_output_zero_control = output_zero_control;
    next_output_one_control  = output_one_control;
    next_reg_rdata           = 8'h00;
    if (reg_write) begin
      unique case (reg_addr)
        ocp_pkg::OFS_CHANNEL_POWER_DOWN:
          next_channel_power_down = reg_wdata & ocp_pkg::MASK_CHANNEL_POWER_DOWN;
        ocp_pkg::OFS_OUTPUT_ZERO_CONTROL:
          next_output_zero_control = reg_wdata & ocp_pkg::MASK_OUTPUT_ZERO_CONTROL;
        ocp_pkg::OFS_OUTPUT_ONE_CONTROL:
          next_output_one_control = reg_wdata & ocp_pkg::MASK_OUTPUT_ONE_CONTROL;
        default: begin
        end
      endcase
    end
    // unmapped addresses read zero
    if (reg_read) begin
      unique case (reg_addr)
        ocp_pkg::OFS_CHANNEL_POWER_DOWN:  next_reg_rdata = channel_power_down;
        ocp_pkg::OFS_OUTPUT_ZERO_CONTROL: next_reg_rdata = output_zero_control;
        ocp_pkg::OFS_OUTPUT_ONE_CONTROL:  next_reg_rdata = output_one_control;
        default:                          next_reg_rdata = 8'h00;
      endcase
    end
  end

  // control decode from the register contents
  always_comb begin
    next_pair_zero_one_off   = channel_power_down[ocp_pkg::POS_PAIR_ZERO_ONE_OFF];
    next_pair_two_three_off  = channel_power_down[ocp_pkg::POS_PAIR_TWO_THREE_OFF];
    next_chan_four_to_seven_off =
      channel_power_down[ocp_pkg::POS_CHAN_SEVEN_OFF:ocp_pkg::POS_CHAN_FOUR_OFF];
    next_single_ended_channel_off = channel_power_down[ocp_pkg::POS_SINGLE_ENDED_CHAN_OFF];
    next_pair_zero_one_source = output_zero_control[ocp_pkg::POS_SOURCE];
    // the power-down bit only stops mux and divider; the buffers follow format alone
    next_pair_zero_one_run = !channel_power_down[ocp_pkg::POS_PAIR_ZERO_ONE_OFF];
  end

  ocp_driver_decode u_zero (
    .fmt      (output_zero_control[ocp_pkg::POS_FMT_HI:ocp_pkg::POS_FMT_LO]),
    .drive_a  (output_zero_control[ocp_pkg::POS_DRA_HI:ocp_pkg::POS_DRA_LO]),
    .drive_b  (output_zero_control[ocp_pkg::POS_DRB_HI:ocp_pkg::POS_DRB_LO]),
    .drv_on   (z_on),
    .diff_on  (z_diff),
    .hcsl_on  (z_hcsl),
    .tail_sel (z_tail),
    .load_sel (z_load),
    .p_en     (z_pins[0]),
    .p_low    (z_pins[1]),
    .p_inv    (z_pins[2]),
    .n_en     (z_pins[3]),
    .n_low    (z_pins[4]),
    .n_inv    (z_pins[5])
  );

  ocp_driver_decode u_one (
    .fmt      (output_one_control[ocp_pkg::POS_FMT_HI:ocp_pkg::POS_FMT_LO]),
    .drive_a  (output_one_control[ocp_pkg::POS_DRA_HI:ocp_pkg::POS_DRA_LO]),
    .drive_b  (output_one_control[ocp_pkg::POS_DRB_HI:ocp_pkg::POS_DRB_LO]),
    .drv_on   (o_on),
    .diff_on  (o_diff),
    .hcsl_on  (o_hcsl),
    .tail_sel (o_tail),
    .load_sel (o_load),
    .p_en     (o_pins[0]),
    .p_low    (o_pins[1]),
    .p_inv    (o_pins[2]),
    .n_en     (o_pins[3]),
    .n_low    (o_pins[4]),
    .n_inv    (o_pins[5])
  );

  // registers; outputs trail the register file by one clock
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      channel_power_down       <= ocp_pkg::RST_CHANNEL_POWER_DOWN;
      output_zero_control      <= ocp_pkg::RST_OUTPUT_ZERO_CONTROL;
      output_one_control       <= ocp_pkg::RST_OUTPUT_ONE_CONTROL;
      reg_rdata                <= 8'h00;
      pair_zero_one_off        <= 1'b0;
      pair_two_three_off       <= 1'b0;
      chan_four_to_seven_off   <= 4'h0;
      single_ended_channel_off <= 1'b0;
      pair_zero_one_source     <= ocp_pkg::SRC_SECOND_SYNTH;
      pair_zero_one_run        <= 1'b1;
      out_zero_drv_on          <= 1'b1;
      out_zero_diff_on         <= 1'b1;
      out_zero_hcsl_on         <= 1'b0;
      out_zero_tail_sel        <= ocp_pkg::TAIL_8MA;
      out_zero_load_sel        <= 3'h0;
      out_zero_pins            <= 6'h00;
      out_one_drv_on           <= 1'b1;
      out_one_diff_on          <= 1'b1;
      out_one_hcsl_on          <= 1'b0;
      out_one_tail_sel         <= ocp_pkg::TAIL_8MA;
      out_one_load_sel         <= 3'h0;
      out_one_pins             <= 6'h00;
    end else begin
      channel_power_down       <= next_channel_power_down;
      output_zero_control      <= next_output_zero_control;
      output_one_control       <= next_output_one_control;
      reg_rdata                <= next_reg_rdata;
      pair_zero_one_off        <= next_pair_zero_one_off;
      pair_two_three_off       <= next_pair_two_three_off;
      chan_four_to_seven_off   <= next_chan_four_to_seven_off;
      single_ended_channel_off <= next_single_ended_channel_off;
      pair_zero_one_source     <= next_pair_zero_one_source;
      pair_zero_one_run        <= next_pair_zero_one_run;
      out_zero_drv_on          <= z_on;
      out_zero_diff_on         <= z_diff;
      out_zero_hcsl_on         <= z_hcsl;
      out_zero_tail_sel        <= z_tail;
      out_zero_load_sel        <= z_load;
      out_zero_pins            <= z_pins;
      out_one_drv_on           <= o_on;
      out_one_diff_on          <= o_diff;
      out_one_hcsl_on          <= o_hcsl;
      out_one_tail_sel         <= o_tail;
      out_one_load_sel         <= o_load;
      out_one_pins             <= o_pins;
    end
  end
endmodule

/* dv/ocp_checker.sv */
// concurrent checks on the register port and decoded controls
`timescale 1ns/1ps
module ocp_checker (
  // clock and reset
  input wire logic       clock,
  input wire logic       reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  // power-down and source
  input wire logic       pair_zero_one_off,
  input wire logic       pair_two_three_off,
  input wire logic [3:0] chan_four_to_seven_off,
  input wire logic       single_ended_channel_off,
  input wire logic       pair_zero_one_source,
  input wire logic       pair_zero_one_run,
  // drivers
  input wire logic       out_zero_drv_on,
  input wire logic       out_zero_hcsl_on,
  input wire logic [3:0] out_zero_tail_sel,
  input wire logic [2:0] out_zero_load_sel,
  input wire logic [5:0] out_zero_pins,
  input wire logic       out_one_drv_on,
  input wire logic [5:0] out_one_pins
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic wpd, wz, wo;
  assign wpd = reg_write && reg_addr == 8'h1e;
  assign wz  = reg_write && reg_addr == 8'h1f;
  assign wo  = reg_write && reg_addr == 8'h20;
  // decoded outputs lag the register by one edge, so two after the strobe
  a_rdata_quiet: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero");
  a_pair_lo_off: assert property (wpd |-> ##2 pair_zero_one_off == $past(reg_wdata[0], 2) &&
    pair_zero_one_run != pair_zero_one_off) else $error("pair 0/1 off wrong");
  a_pair_hi_off: assert property (wpd |-> ##2 pair_two_three_off == $past(reg_wdata[1], 2))
    else $error("pair 2/3 off wrong");
  a_upper_chan_off: assert property (wpd |-> ##2 chan_four_to_seven_off == $past(reg_wdata[5:2], 2))
    else $error("channel 4-7 off wrong");
  a_single_off: assert property (wpd |-> ##2 single_ended_channel_off == $past(reg_wdata[6], 2))
    else $error("single-ended off wrong");
  a_source_pick: assert property (wz |-> ##2 pair_zero_one_source == $past(reg_wdata[7], 2))
    else $error("source select wrong");
  a_format_off: assert property (wz && reg_wdata[6:5] == 2'h0 |-> ##2 !out_zero_drv_on &&
    out_zero_tail_sel == 4'h0 && out_zero_pins == 6'h00) else $error("driver not off");
  a_hcsl_tail: assert property (wz && reg_wdata[6:5] == 2'h2 |-> ##2 out_zero_hcsl_on &&
    out_zero_tail_sel == 4'h1 << $past(reg_wdata[4:3], 2)) else $error("tail current wrong");
  a_hcsl_load: assert property (wz && reg_wdata[6:5] == 2'h2 |-> ##2
    out_zero_load_sel == (4'h1 << $past(reg_wdata[2:1], 2)) >> 1) else $error("load wrong");
  a_one_cmos: assert property (wo && reg_wdata[6:5] == 2'h3 |-> ##2 out_one_drv_on &&
    out_one_pins[0] == ($past(reg_wdata[4:3], 2) != 2'h0) &&
    out_one_pins[3] == ($past(reg_wdata[2:1], 2) != 2'h0)) else $error("output 1 pins wrong");
  c_read: cover property (reg_read ##1 reg_rdata != 8'h00);
  c_all_off: cover property (wpd && reg_wdata == 8'hff);
  c_hcsl: cover property (out_zero_hcsl_on && out_zero_load_sel == 3'h4);
endmodule
bind ocp_top ocp_checker i_ocp_checker (.clock, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .pair_zero_one_off, .pair_two_three_off, .chan_four_to_seven_off, .single_ended_channel_off,
  .pair_zero_one_source, .pair_zero_one_run, .out_zero_drv_on, .out_zero_hcsl_on, .out_zero_tail_sel,
  .out_zero_load_sel, .out_zero_pins, .out_one_drv_on, .out_one_pins);

/* dv/ocp_top_tb.sv */
// self-checking bench for the output channel power control registers
`timescale 1ns/1ps
module ocp_top_tb;
  logic        clock = 1'b0;
  logic        reset_n, reg_write, reg_read, rd_seen, src, run;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, v0, v1, r;
  // nets: each slice is driven by its own output port
  wire  [6:0]  pd;
  wire  [15:0] o0, o1;
  logic [7:0]  exp_q[$];
  int          errors, total_checks;
  ocp_top i_ocp_top (.clock, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .pair_zero_one_off(pd[0]), .pair_two_three_off(pd[1]), .chan_four_to_seven_off(pd[5:2]),
    .single_ended_channel_off(pd[6]), .pair_zero_one_source(src), .pair_zero_one_run(run),
    .out_zero_drv_on(o0[15]), .out_zero_diff_on(o0[14]), .out_zero_hcsl_on(o0[13]),
    .out_zero_tail_sel(o0[12:9]), .out_zero_load_sel(o0[8:6]), .out_zero_pins(o0[5:0]),
    .out_one_drv_on(o1[15]), .out_one_diff_on(o1[14]), .out_one_hcsl_on(o1[13]),
    .out_one_tail_sel(o1[12:9]), .out_one_load_sel(o1[8:6]), .out_one_pins(o1[5:0]));
  always #2.5 clock = ~clock;
  function automatic logic [2:0] pin(logic [1:0] m);
    pin = {m == 2'h2, m == 2'h1, m != 2'h0};
  endfunction
  // expected {drv, diff, hcsl, tail, load, pins} from a control byte
  function automatic logic [15:0] dec(logic [7:0] v);
    logic [1:0] f, a, b;
    logic [3:0] t;
    f = v[6:5];
    a = v[4:3];
    b = v[2:1];
    t = (f == 2'h2) ? 4'h1 << a : (f == 2'h1) ? ((a == 2'h3) ? 4'h4 : 4'h1 << a) : 4'h0;
    dec = {f != 2'h0, f == 2'h1 || f == 2'h2, f == 2'h2, t,
      (f == 2'h2) ? 3'((4'h1 << b) >> 1) : 3'h0, (f == 2'h3) ? {pin(b), pin(a)} : 6'h00};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    reg_read  <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr  <= a;
    reg_write <= 1'b0;
    reg_read  <= 1'b1;
    exp_q.push_back(e);
  endtask
  // the #1 lets the decoded outputs of this edge land before they are looked at
  task automatic idle();
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read  <= 1'b0;
    #1;
  endtask
  task automatic do_reset();
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // read replies stand only in the cycle after the strobe
  always @(posedge clock) begin
    rd_seen <= reg_read;
    if (rd_seen) begin
      chk({8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
    end
  end
  initial begin
    #(20000 * 5);
    errors++;
    report_and_stop();
  end
  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    void'($urandom(9930));
    do_reset();
    rd(8'h1e, 8'h00);
    rd(8'h1f, 8'hb0);
    rd(8'h20, 8'h30);
    idle();
    chk(o0, dec(8'hb0));
    chk(o1, dec(8'h30));
    chk({src, run, pd}, 9'h180);
    for (int i = 0; i < 8; i++) begin
      v0 = (i == 7) ? 8'hff : 8'h01 << i;
      wr(8'h1e, v0);
      rd(8'h1e, v0 & 8'h7f);
      idle();
      chk({src, run, pd}, {1'b1, ~v0[0], v0[6:0]});
    end
    // every format and drive code on output 0, random bytes with reserved bits on output 1
    for (int i = 0; i < 64; i++) begin
      r = 8'($urandom);
      v0 = {r[7], i[5:0], r[0]};
      v1 = 8'($urandom);
      wr(8'h1f, v0);
      wr(8'h20, v1);
      rd(8'h1f, v0 & 8'hfe);
      rd(8'h20, v1 & 8'h7e);
      idle();
      chk(o0, dec(v0));
      chk(o1, dec(v1));
      chk({15'h0000, src}, {15'h0000, v0[7]});
    end
    for (int i = 0; i < 4; i++) begin
      r = 8'($urandom);
      if (r >= 8'h1e && r <= 8'h20) r = 8'h00;
      wr(r, 8'hff);
      rd(r, 8'h00);
    end
    rd(8'h1e, 8'h7f);
    idle();
    do_reset();
    rd(8'h1f, 8'hb0);
    idle();
    chk({src, run, pd}, 9'h180);
    repeat (3) idle();
    report_and_stop();
  end
endmodule
